// file: logic/uart_regs.svh
/*
 Register offsets, field positions, reset values and timing counts of the host serial port.
 Assumes a 125 MHz system clock and an APB slave decoding the low address byte.
*/
`ifndef UART_REGS_SVH
`define UART_REGS_SVH
// Clock and timing
`define CLK_HZ       125000000
`define BAUD_RST     115200
`define DIV_RST      (`CLK_HZ / `BAUD_RST)
`define BRK_THR_MS   100
`define BRK_THR_CYC  (`CLK_HZ / 1000 * `BRK_THR_MS)
`define WAKE_US      1000
`define WAKE_CYC     (`CLK_HZ / 1000000 * `WAKE_US)
// Register byte offsets
`define A_CTRL       8'h00
`define A_DIV        8'h04
`define A_THR        8'h08
`define A_DATA       8'h0c
`define A_STAT       8'h10
`define A_MASK       8'h14
`define A_STATE      8'h18
`define A_BLEN       8'h1c
`define A_WAKE       8'h20
// Control fields
`define C_FLOW       0
`define C_PAR        1
`define C_TWO_STOP   3
`define C_WAKE       4
`define C_BRK        5
// Status fields, write one to clear
`define S_RXD        0
`define S_PERR       1
`define S_FERR       2
`define S_BRK        3
`define S_TXD        4
`define S_OVR        5
`define S_RST        6
`endif

// file: logic/uart_pkg.sv
/*
 Types shared by the serial port modules: parity mode and the two line state machines.
 Assumes nothing beyond the register header.
*/
package uart_pkg;
   typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_ODD = 2'h1, PAR_EVEN = 2'h2} parity_e;
   // Gray codes along the usual path
   typedef enum logic [2:0] {RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3,
                             RX_PAR = 3'h2, RX_STOP = 3'h6, RX_WAITH = 3'h4} rx_state_e;
   typedef enum logic [2:0] {TX_IDLE = 3'h0, TX_BRK = 3'h1, TX_GAP = 3'h3, TX_START = 3'h2,
                             TX_DATA = 3'h6, TX_PAR = 3'h7, TX_STOP = 3'h5} tx_state_e;
   // Parity bit that goes with a byte in the given mode
   function automatic logic par_bit(input logic [7:0] d, input parity_e m);
      par_bit = (^d) ^ (m == PAR_ODD);
   endfunction
endpackage

// file: logic/tx_if.sv
/*
 Carrier between the port controller and its serialiser.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface tx_if import uart_pkg::*;;
   logic        go;
   logic        with_brk;
   logic        with_data;
   logic [7:0]  data;
   parity_e     par;
   logic        two_stop;
   logic [19:0] div;
   logic [31:0] brk_len;
   logic        busy;
   logic        done;
   logic        line;
   modport ctl (output go, with_brk, with_data, data, par, two_stop, div, brk_len,
                input busy, done, line);
   modport ser (input go, with_brk, with_data, data, par, two_stop, div, brk_len,
                output busy, done, line);
endinterface

// file: logic/uart_tx.sv
/*
 Serialiser: optional break with a high gap, then one framed character unless the break stands alone.
 Assumes go is a one-cycle pulse given only while busy is low, and div of at least 2.
*/
`timescale 1ns/1ps
`include "uart_regs.svh"
module uart_tx import uart_pkg::*; (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Controller side
   tx_if.ser        t
);
   typedef struct packed {
      tx_state_e   st;
      logic [31:0] cnt;
      logic [2:0]  bitn;
      logic [7:0]  sh;
      logic        pb;
      logic        dat;
      logic        busy;
      logic        done;
      logic        line;
   } txs_s;
   txs_s q;
   txs_s next_q;

   function automatic logic [31:0] bit_len(input logic [19:0] d);
      bit_len = {12'h000, d} - 32'h1;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Line sequencing; each bit lasts div cycles
   always_comb begin
      next_q = q;
      next_q.done = 1'b0;
      if (q.cnt != 32'h0)
         next_q.cnt = q.cnt - 32'h1;
      unique case (q.st)
         TX_IDLE: begin
            next_q.line = 1'b1;                               // Idle high
            if (t.go) begin
               next_q.sh = t.data;
               next_q.pb = par_bit(t.data, t.par);
               next_q.dat = t.with_data;
               next_q.busy = t.with_brk | t.with_data;
               if (t.with_brk) begin
                  next_q.st = TX_BRK;                        // Wake the host first
                  next_q.cnt = t.brk_len - 32'h1;
                  next_q.line = 1'b0;
               end else if (t.with_data) begin
                  next_q.st = TX_START;
                  next_q.cnt = bit_len(t.div);
                  next_q.line = 1'b0;
               end
            end
         end
         TX_BRK: if (q.cnt == 32'h0) begin
            next_q.st = TX_GAP;                               // High gap so the start bit shows
            next_q.cnt = bit_len(t.div);
            next_q.line = 1'b1;
         end
         TX_GAP: if (q.cnt == 32'h0) begin
            if (q.dat) begin
               next_q.st = TX_START;                         // Data only after the break
               next_q.cnt = bit_len(t.div);
               next_q.line = 1'b0;
            end else begin
               next_q.st = TX_IDLE;
               next_q.busy = 1'b0;
               next_q.done = 1'b1;
            end
         end
         TX_START: if (q.cnt == 32'h0) begin
            next_q.st = TX_DATA;                              // LSB first
            next_q.cnt = bit_len(t.div);
            next_q.bitn = 3'h0;
            next_q.line = q.sh[0];
         end
         TX_DATA: if (q.cnt == 32'h0) begin
            next_q.cnt = bit_len(t.div);
            next_q.sh = q.sh >> 1;
            if (q.bitn == 3'h7) begin
               next_q.bitn = 3'h0;
               next_q.st = (t.par == PAR_NONE) ? TX_STOP : TX_PAR;
               next_q.line = (t.par == PAR_NONE) ? 1'b1 : q.pb;
            end else begin
               next_q.bitn = q.bitn + 3'h1;
               next_q.line = q.sh[1];
            end
         end
         TX_PAR: if (q.cnt == 32'h0) begin
            next_q.st = TX_STOP;
            next_q.cnt = bit_len(t.div);
            next_q.line = 1'b1;
         end
         TX_STOP: if (q.cnt == 32'h0) begin
            if (t.two_stop && q.bitn == 3'h0) begin
               next_q.bitn = 3'h1;                           // Second stop bit
               next_q.cnt = bit_len(t.div);
            end else begin
               next_q.st = TX_IDLE;
               next_q.busy = 1'b0;
               next_q.done = 1'b1;
            end
         end
         default: next_q.st = TX_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         q <= '0;
         q.line <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   assign t.busy = q.busy;
   assign t.done = q.done;
   assign t.line = q.line;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_gap_high;
      (q.st == TX_GAP && t.line) [*2];
   endsequence
   a_tx_idle_high: assert property (@(posedge sys_clk) disable iff (srst)
      q.st == TX_IDLE |-> t.line) else $error("line low while idle");
   a_tx_start_low: assert property (@(posedge sys_clk) disable iff (srst)
      q.st == TX_START |-> !t.line) else $error("start bit not low");
   a_tx_brk_low: assert property (@(posedge sys_clk) disable iff (srst)
      q.st == TX_BRK |-> !t.line && t.busy) else $error("break not low");
   a_tx_gap_after: assert property (@(posedge sys_clk) disable iff (srst)
      q.st == TX_BRK && q.cnt == 32'h0 |=> s_gap_high) else $error("no gap after break");
endmodule

// file: logic/uart_host_port.sv
/*
 Host serial port with APB registers, flow control, break detection and break-driven reset.
 Assumes uart_rx and cts_n are synchronous to sys_clk, and the APB master is standard.
*/
// Added by the designer: the address map and the APB interface to the registers.
// What this block does
// - Bytes arrive on uart_rx and leave on uart_tx, the host crossing the two lines.
// - With flow control on, rts_n and cts_n are low-true and a character starts only with cts_n low.
// - Divisor, parity none/odd/even, one or two stop bits and flow are programmable; data is fixed at eight bits.
// - A continuous low on uart_rx is a break and its length in cycles is measured.
// - A break longer than the threshold resets the port and pulses module_reset.
// - Software can drive uart_tx low for a break period to wake the host.
// - A break present at the pin reset holds the port in low power until the line goes high.
// - When enabled, every character is preceded by a wake break.
`timescale 1ns/1ps
`include "uart_regs.svh"
module uart_host_port import uart_pkg::*; #(
   parameter logic [31:0] BRK_THR  = `BRK_THR_CYC,
   parameter logic [31:0] WAKE_LEN = `WAKE_CYC
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        srst,
   // APB slave
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial pins
   input  wire logic        uart_rx,
   output logic             uart_tx,
   input  wire logic        cts_n,
   output logic             rts_n,
   // System
   output logic             irq,
   output logic             module_reset,
   output logic             low_power
);
   typedef struct packed {
      logic [4:0]  ctrl;
      logic [19:0] div;
      logic [31:0] thr;
      logic [31:0] wake;
      logic [6:0]  stat;
      logic [6:0]  mask;
      logic [31:0] blen;
      logic        rxq;
      logic        fired;
      logic        hold;
      rx_state_e   rst;
      logic [19:0] rcnt;
      logic [2:0]  rbit;
      logic [7:0]  rsh;
      logic [7:0]  rdat;
      logic        rfull;
      logic        pend;
      logic [7:0]  tdat;
      logic        brk_req;
      logic        go;
      logic        gbrk;
      logic        gdat;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
      logic        mrst;
      logic        rts_n;
   } top_s;
   top_s q;
   top_s next_q;
   logic fire;
   logic tx_rst;
   tx_if t ();

   // Values after reset; shared by the pin reset and the break reset
   function automatic top_s rst_val();
      top_s v;
      v = '0;
      v.div = 20'(`DIV_RST);
      v.thr = BRK_THR;
      v.wake = WAKE_LEN;
      v.rxq = 1'b1;
      return v;
   endfunction

   function automatic logic [19:0] bitm1(input logic [19:0] d);
      bitm1 = d - 20'h1;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Break long enough to reset; not during the boot hold, once per break
   assign fire = !uart_rx && !q.fired && !q.hold && (q.blen >= q.thr);
   assign tx_rst = srst | q.mrst;

   // Serialiser
   assign t.go = q.go;
   assign t.with_brk = q.gbrk;
   assign t.with_data = q.gdat;
   assign t.data = q.tdat;
   assign t.par = parity_e'(q.ctrl[`C_PAR +: 2]);
   assign t.two_stop = q.ctrl[`C_TWO_STOP];
   assign t.div = q.div;
   assign t.brk_len = q.wake;

   uart_tx u_tx (
      .sys_clk (sys_clk),
      .srst    (tx_rst),
      .t       (t)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Registers, receiver, launch control
   always_comb begin
      logic [6:0] setb;
      logic       wr;
      logic       rd;
      logic       ok;
      top_s       bus;
      setb = 7'h00;
      bus = '0;
      next_q = q;
      wr = psel && penable && q.pready && pwrite;
      rd = psel && penable && q.pready && !pwrite;
      ok = 1'b0;
      next_q.go = 1'b0;
      next_q.mrst = 1'b0;
      next_q.rxq = uart_rx;
      // Break length of the current or last low stretch
      if (!uart_rx) begin
         if (q.rxq)
            next_q.blen = 32'h1;
         else if (q.blen != 32'hffffffff)
            next_q.blen = q.blen + 32'h1;
      end else begin
         next_q.fired = 1'b0;
         next_q.hold = 1'b0;                                  // Boot hold ends on a high line
      end
      // Receiver, sampling at mid-bit
      if (q.rcnt != 20'h0)
         next_q.rcnt = q.rcnt - 20'h1;
      unique case (q.rst)
         RX_IDLE: if (!uart_rx && !q.hold) begin
            next_q.rst = RX_START;
            next_q.rcnt = q.div >> 1;
         end
         RX_START: if (q.rcnt == 20'h0) begin
            next_q.rst = uart_rx ? RX_IDLE : RX_DATA;        // A short glitch is dropped
            next_q.rcnt = bitm1(q.div);
            next_q.rbit = 3'h0;
         end
         RX_DATA: if (q.rcnt == 20'h0) begin
            next_q.rsh = {uart_rx, q.rsh[7:1]};              // LSB first
            next_q.rcnt = bitm1(q.div);
            next_q.rbit = q.rbit + 3'h1;
            if (q.rbit == 3'h7)
               next_q.rst = (t.par == PAR_NONE) ? RX_STOP : RX_PAR;
         end
         RX_PAR: if (q.rcnt == 20'h0) begin
            setb[`S_PERR] = uart_rx != par_bit(q.rsh, t.par);
            next_q.rst = RX_STOP;
            next_q.rcnt = bitm1(q.div);
         end
         RX_STOP: if (q.rcnt == 20'h0) begin
            if (!uart_rx) begin
               setb[`S_FERR] = 1'b1;
               setb[`S_BRK] = q.rsh == 8'h00;                // All-low frame is a break
               next_q.rst = RX_WAITH;
            end else begin
               next_q.rst = RX_IDLE;
               next_q.rdat = q.rsh;
               next_q.rfull = 1'b1;
               setb[`S_RXD] = 1'b1;
               setb[`S_OVR] = q.rfull;                       // Old byte overwritten
            end
         end
         RX_WAITH: if (uart_rx)
            next_q.rst = RX_IDLE;
         default: next_q.rst = RX_IDLE;
      endcase
      setb[`S_TXD] = t.done;
      // Launch one character or break; cts_n checked per character
      if (!q.go && !t.busy && !q.hold) begin
         if (q.brk_req) begin
            next_q.go = 1'b1;                                // Stand-alone wake break
            next_q.gbrk = 1'b1;
            next_q.gdat = 1'b0;
            next_q.brk_req = 1'b0;
         end else if (q.pend && (!q.ctrl[`C_FLOW] || !cts_n)) begin
            next_q.go = 1'b1;
            next_q.gbrk = q.ctrl[`C_WAKE];
            next_q.gdat = 1'b1;
            next_q.pend = 1'b0;
         end
      end
      // APB answer one cycle after setup
      next_q.pready = psel && !penable;
      if (psel && !penable) begin
         ok = 1'b1;
         unique case (paddr)
            `A_CTRL:  next_q.prdata = {27'h0, q.ctrl};
            `A_DIV:   next_q.prdata = {12'h0, q.div};
            `A_THR:   next_q.prdata = q.thr;
            `A_DATA:  next_q.prdata = {24'h0, q.rdat};
            `A_STAT:  next_q.prdata = {25'h0, q.stat};
            `A_MASK:  next_q.prdata = {25'h0, q.mask};
            `A_STATE: next_q.prdata = {27'h0, q.hold, !q.rxq, q.pend, q.rfull, t.busy};
            `A_BLEN:  next_q.prdata = q.blen;
            `A_WAKE:  next_q.prdata = q.wake;
            default: begin
               next_q.prdata = 32'h0;
               ok = 1'b0;
            end
         endcase
         next_q.pslverr = !ok;
      end
      if (rd && paddr == `A_DATA)
         next_q.rfull = setb[`S_RXD];                        // Read frees the holding byte
      if (wr) begin
         unique case (paddr)
            `A_CTRL: begin
               next_q.ctrl = pwdata[4:0];
               next_q.brk_req = next_q.brk_req | pwdata[`C_BRK];  // A launched break is not re-armed
            end
            `A_DIV:  next_q.div = pwdata[19:0];
            `A_THR:  next_q.thr = pwdata;
            `A_DATA: if (!q.pend) begin
               next_q.pend = 1'b1;                           // Ignored while one is waiting
               next_q.tdat = pwdata[7:0];
            end
            `A_MASK: next_q.mask = pwdata[6:0];
            `A_WAKE: next_q.wake = pwdata;
            default: ;
         endcase
      end
      // Sticky status; a new event wins over a clear
      next_q.stat = (q.stat & ~((wr && paddr == `A_STAT) ? pwdata[6:0] : 7'h00)) | setb;
      // Break reset: everything back to defaults except the one-shot guard, the APB answer, rxq and blen; RST flag and module_reset set
      if (fire) begin
         bus = next_q;
         next_q = rst_val();
         // A bus transfer in flight still gets its answer, so the master never hangs
         next_q.pready = bus.pready;
         next_q.prdata = bus.prdata;
         next_q.pslverr = bus.pslverr;
         next_q.fired = 1'b1;
         next_q.mrst = 1'b1;
         next_q.rxq = uart_rx;
         next_q.blen = q.blen;
         next_q.stat[`S_RST] = 1'b1;
      end
      next_q.rts_n = next_q.ctrl[`C_FLOW] & next_q.rfull;    // Low while a byte fits
      next_q.irq = |(next_q.stat & next_q.mask);
   end

   // State register; the pin reset starts in the boot hold
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         q <= rst_val();
         q.hold <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   // Outputs straight from flip-flops
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign uart_tx = t.line;
   assign rts_n = q.rts_n;
   assign irq = q.irq;
   assign module_reset = q.mrst;
   assign low_power = q.hold;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   a_cts_gates_tx: assert property (@(posedge sys_clk) disable iff (srst)
      next_q.go && next_q.gdat && !q.brk_req |-> !q.ctrl[`C_FLOW] || !cts_n)
      else $error("character started with cts_n high");
   a_rts_when_full: assert property (@(posedge sys_clk) disable iff (srst)
      q.ctrl[`C_FLOW] && q.rfull |-> rts_n) else $error("rts_n low with byte held");
   a_brk_measure: assert property (@(posedge sys_clk) disable iff (srst)
      !uart_rx && !q.rxq && !fire && q.blen < 32'h7fffffff |=> q.blen == $past(q.blen) + 32'h1)
      else $error("break length not counted");
   a_brk_reset: assert property (@(posedge sys_clk) disable iff (srst)
      fire |=> module_reset ##1 (!module_reset && !q.stat[`S_RST] == 1'b0))
      else $error("long break did not reset");
   a_reset_once: assert property (@(posedge sys_clk) disable iff (srst)
      module_reset && !uart_rx |=> !module_reset [*2]) else $error("reset repeated");
   a_boot_hold: assert property (@(posedge sys_clk) disable iff (srst)
      low_power && !uart_rx |=> low_power && q.rst == RX_IDLE) else $error("hold left early");
   a_irq_level: assert property (@(posedge sys_clk) disable iff (srst)
      irq == |(q.stat & q.mask)) else $error("irq disagrees with status");
   a_apb_answer: assert property (@(posedge sys_clk) disable iff (srst)
      psel && !penable |=> pready) else $error("no answer after setup");
   a_wake_first: assert property (@(posedge sys_clk) disable iff (srst)
      q.go && q.gdat && q.ctrl[`C_WAKE] &&
      !$past(psel && penable && pready && pwrite && paddr == `A_CTRL) |=> !uart_tx)
      else $error("no wake break before data");
   a_tx_after_rst: assert property (@(posedge sys_clk) disable iff (srst)
      module_reset |=> uart_tx) else $error("line not idle after break reset");
endmodule

// file: tb/host_model.sv
/*
 Host side of the serial link: sends characters and breaks, samples the port's output.
 Assumes the port's clock and one bit every div clock cycles.
*/
`timescale 1ns/1ps
module host_model (
   // Clock
   input  wire logic sys_clk,
   // Lines from the port
   input  wire logic uart_tx,
   input  wire logic rts_n,
   // Lines to the port
   output logic      uart_rx,
   output logic      cts_n
);
   // Boot starts with a held break; host ready to take data
   initial begin
      uart_rx = 1'b0;
      cts_n   = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // One level for n cycles, changed just after an edge
   task automatic put(input logic b, input int n);
      @(posedge sys_clk);
      uart_rx <= b;
      repeat (n - 1) @(posedge sys_clk);
   endtask
   // Whole character; holds off while the port is not ready
   task automatic send_byte(input logic [7:0] d, input logic use_p, input logic pb, input int div);
      logic [10:0] f;
      f = {1'b1, use_p ? pb : 1'b1, d, 1'b0};
      // No limit of its own: a hang is caught by the bench watchdog
      while (rts_n !== 1'b0) @(posedge sys_clk);
      for (int i = 0; i < 11; i++) put(f[i], div);
   endtask
   // Ready indication towards the port, changed at once when called, without waiting for an edge
   task automatic set_cts(input logic v);
      cts_n <= v;
   endtask
   // Break of n cycles, then idle high
   task automatic hold_low(input int n);
      put(1'b0, n);
      put(1'b1, 1);
   endtask
   // Wait for the port's line to go low; the bench watchdog bounds it
   task automatic wait_fall();
      while (uart_tx !== 1'b0) @(posedge sys_clk);
   endtask
   // Length of one low stretch in cycles
   task automatic low_len(output int n);
      wait_fall();
      n = 0;
      while (uart_tx === 1'b0) begin
         @(posedge sys_clk);
         n++;
      end
   endtask
   // Start, eight data and two further slots, each sampled mid-bit
   task automatic rx_frame(input int div, output logic [10:0] f);
      wait_fall();
      repeat (div / 2) @(posedge sys_clk);
      for (int i = 0; i < 11; i++) begin
         f[i] = uart_tx;
         repeat (div) @(posedge sys_clk);
      end
   endtask
endmodule

// file: tb/tb_top.sv
/*
 Testbench of the host serial port: APB register calls with expected values.
 Assumes the host model on the serial pins; thresholds shortened by parameter.
*/
`timescale 1ns/1ps
`include "uart_regs.svh"
module tb_top import uart_pkg::*;;
   logic        sys_clk = 1'b0;
   logic        srst    = 1'b1;
   logic [7:0]  paddr   = 8'h00;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, uart_rx, uart_tx, cts_n, rts_n;
   logic        irq, module_reset, low_power;
   logic [10:0] fr;
   logic [7:0]  tx_d [3] = '{8'ha5, 8'h3c, 8'h80};
   parity_e     tx_p [3] = '{PAR_NONE, PAR_ODD, PAR_EVEN};
   int          error_cnt = 0;
   int          check_count = 0;
   int          pulses = 0;
   int          n;
   logic        pb;
   uart_host_port #(.BRK_THR(32'h000000c8), .WAKE_LEN(32'h00000014)) uut (
      .sys_clk(sys_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .uart_rx(uart_rx), .uart_tx(uart_tx), .cts_n(cts_n), .rts_n(rts_n), .irq(irq),
      .module_reset(module_reset), .low_power(low_power));
   host_model host (.sys_clk(sys_clk), .uart_tx(uart_tx), .rts_n(rts_n), .uart_rx(uart_rx),
      .cts_n(cts_n));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, and a count of port reset pulses
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (module_reset === 1'b1) pulses++;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One APB transfer; waits for pready without assuming a latency
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel   <= 1'b1;
      paddr  <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Watchdog, well past the length of the sequence
   initial begin
      repeat (60000) @(posedge sys_clk);
      error_cnt++;
      print_verdict();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk("low_power held", low_power, 32'h1);
      apb(0, `A_DIV, 0);
      chk("div reset", rd, `DIV_RST);
      apb(0, 8'h24, 0);
      chk("unmapped", {err, rd[30:0]}, 32'h80000000);
      host.put(1'b1, 3);
      chk("low_power freed", low_power, 32'h0);
      apb(1, `A_DIV, 32'h8);
      // Every parity mode, two stop bits once; irq stays masked
      for (int i = 0; i < 3; i++) begin
         apb(1, `A_CTRL, {tx_p[i], 1'b0} | ((i == 1) << `C_TWO_STOP));
         apb(1, `A_DATA, tx_d[i]);
         host.rx_frame(8, fr);
         pb = (tx_p[i] == PAR_NONE) ? 1'b1 : (^tx_d[i]) ^ (tx_p[i] == PAR_ODD);
         chk("tx frame", fr, {1'b1, pb, tx_d[i], 1'b0});
      end
      apb(0, `A_STAT, 0);
      chk("tx done masked", {rd[`S_TXD], irq}, 32'h2);
      apb(1, `A_MASK, 32'h1 << `S_TXD);
      repeat (2) @(posedge sys_clk);
      chk("irq raised", irq, 32'h1);
      apb(1, `A_STAT, 32'h1 << `S_TXD);
      repeat (2) @(posedge sys_clk);
      chk("irq cleared", irq, 32'h0);
      // Receive with even parity and flow control, then a parity fault
      apb(1, `A_CTRL, 32'h5);
      host.send_byte(8'h69, 1'b1, ^8'h69, 8);
      repeat (8) @(posedge sys_clk);
      chk("rts busy", rts_n, 32'h1);
      apb(0, `A_DATA, 0);
      chk("rx byte", rd, 32'h69);
      @(posedge sys_clk);
      chk("rts free", rts_n, 32'h0);
      host.send_byte(8'h69, 1'b1, ~^8'h69, 8);
      repeat (8) @(posedge sys_clk);
      apb(0, `A_STAT, 0);
      chk("parity err", rd[`S_PERR], 32'h1);
      // A character waits while the host is not ready
      host.set_cts(1'b1);
      apb(1, `A_DATA, 32'h0f);
      repeat (40) @(posedge sys_clk);
      chk("held by cts", uart_tx, 32'h1);
      host.set_cts(1'b0);
      host.rx_frame(8, fr);
      chk("frame after cts", fr, {1'b1, ^8'h0f, 8'h0f, 1'b0});
      // Wake break before data, then a break on demand
      apb(1, `A_CTRL, 32'h1 << `C_WAKE);
      apb(1, `A_DATA, 32'h81);
      host.low_len(n);
      chk("wake length", n, 32'd20);
      host.rx_frame(8, fr);
      chk("frame after wake", fr, {2'h3, 8'h81, 1'b0});
      apb(1, `A_CTRL, 32'h1 << `C_BRK);
      host.low_len(n);
      chk("break length", n, 32'd20);
      // Short low is only measured; a long one resets the port
      host.hold_low(50);
      apb(0, `A_BLEN, 0);
      chk("low measured", rd, 32'd50);
      apb(1, `A_THR, 32'd100);
      host.hold_low(120);
      chk("one reset pulse", pulses, 32'd1);
      apb(0, `A_STAT, 0);
      chk("reset flag", rd[`S_RST], 32'h1);
      apb(0, `A_THR, 0);
      chk("thr default", rd, 32'd200);
      print_verdict();
   end
endmodule
